// File: pkg/adcsc_defines.svh
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH
`define ADCSC_OFS_CTRL      4'h0
`define ADCSC_OFS_RESULT    4'h4
`define ADCSC_OFS_CLKDIV    4'h8
`define ADCSC_BIT_DONE      7
`define ADCSC_BIT_IRQEN     6
`define ADCSC_BIT_CONT      5
`define ADCSC_CH_MSB        4
`define ADCSC_DIV_MSB       7
`define ADCSC_DIV_LSB       5
`define ADCSC_CTRL_RST      8'h1f
`define ADCSC_CLKDIV_RST    8'h00
`define ADCSC_CH_OFF        5'h1f
`define ADCSC_CH_REFHI      5'h1d
`define ADCSC_CH_REFLO      5'h1e
`define ADCSC_CONV_TICKS    5'h10
`define ADCSC_LAST_STEP     4'hf
`endif

// File: pkg/adcsc_pkg.sv
package adcsc_pkg;
	typedef logic [7:0] adcsc_byte_t;
	typedef logic [4:0] adcsc_chan_t;
	typedef logic [2:0] adcsc_div_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ARMED = 3'b010,
		ST_CONV  = 3'b100
	} adcsc_state_t;
endpackage : adcsc_pkg

// File: design/adcsc_clkdiv.sv
`include "adcsc_defines.svh"
module adcsc_clkdiv (
	input  wire logic              ref_clk_in,
	input  wire logic              rstn_in,
	input  wire logic              run_in,
	input  wire adcsc_pkg::adcsc_div_t div_sel_in,
	output logic                   tick_out
);
	import adcsc_pkg::*;

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [3:0] last;
	logic       tick_next;
	logic       tick_reg;

	always_comb begin
		case (div_sel_in)
			3'h0:    last = 4'h0;
			3'h1:    last = 4'h1;
			3'h2:    last = 4'h3;
			3'h3:    last = 4'h7;
			default: last = 4'hf;
		endcase
		tick_next = 1'b0;
		cnt_next  = cnt_reg;
		if (!run_in) begin
			cnt_next = 4'h0; // restart phase so a new run counts full period
		end else if (cnt_reg >= last) begin
			cnt_next  = 4'h0;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 4'h1;
		end
	end

	// counter and tick registers
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg  <= 4'h0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_out = tick_reg & run_in;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	property p_div16_spacing;
		tick_out && run_in && div_sel_in[2] && $stable(div_sel_in)
			|=> (!tick_out || !run_in) [*8];
	endproperty
	a_div16_spacing: assert property (p_div16_spacing)
		else $error("converter tick too fast at divide by 16");
endmodule : adcsc_clkdiv

// File: design/adcsc_sar.sv
`include "adcsc_defines.svh"
module adcsc_sar (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  start_in,
	input  wire logic                  abort_in,
	input  wire logic                  tick_in,
	input  wire logic                  comp_in,
	output adcsc_pkg::adcsc_byte_t     dac_code_out,
	output logic                       busy_out,
	output logic                       done_out
);
	import adcsc_pkg::*;

	logic [3:0]  step_reg;
	logic [3:0]  step_next;
	adcsc_byte_t code_reg;
	adcsc_byte_t code_next;
	logic        busy_reg;
	logic        busy_next;
	logic        done_reg;
	logic        done_next;
	logic [2:0]  bit_idx;

	// two ticks per bit, 16 ticks total
	always_comb begin
		step_next = step_reg;
		code_next = code_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		bit_idx   = 3'h7 - step_reg[3:1];
		if (abort_in) begin
			busy_next = 1'b0;
		end else if (start_in) begin
			step_next = 4'h0;
			code_next = 8'h80;
			busy_next = 1'b1;
		end else if (busy_reg && tick_in) begin
			step_next = step_reg + 4'h1;
			if (step_reg[0]) begin
				// keep trial bit only if input at or above dac level
				code_next[bit_idx] = comp_in;
				if (bit_idx != 3'h0)
					code_next[bit_idx - 3'h1] = 1'b1;
			end
			if (step_reg == `ADCSC_LAST_STEP) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	// successive approximation state
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			step_reg <= 4'h0;
			code_reg <= 8'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			step_reg <= step_next;
			code_reg <= code_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign dac_code_out = code_reg;
	assign busy_out     = busy_reg;
	assign done_out     = done_reg;
endmodule : adcsc_sar

// File: design/adcsc_top.sv
// The address map and the Avalon-MM register port were left to the implementer.
`include "adcsc_defines.svh"
module adcsc_top (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rstn_in,
	input  wire logic [3:0]            avs_address_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic [31:0]           avs_writedata_in,
	input  wire logic [3:0]            avs_byteenable_in,
	output logic [31:0]                avs_readdata_out,
	output logic                       avs_waitrequest_out,
	input  wire logic                  stop_mode_in,
	input  wire logic                  comp_in,
	output adcsc_pkg::adcsc_chan_t     mux_sel_out,
	output logic                       ref_high_sel_out,
	output logic                       ref_low_sel_out,
	output logic                       power_down_out,
	output adcsc_pkg::adcsc_byte_t     dac_code_out,
	output logic                       sampling_out,
	output logic                       irq_out
);
	import adcsc_pkg::*;

	// register state
	adcsc_byte_t  ctrl_reg;
	adcsc_byte_t  ctrl_next;
	adcsc_byte_t  result_reg;
	adcsc_byte_t  result_next;
	adcsc_byte_t  clkdiv_reg;
	adcsc_byte_t  clkdiv_next;
	logic         done_flag_reg;
	logic         done_flag_next;
	logic         irq_reg;
	logic         irq_next;
	logic         ack_reg;
	logic         ack_next;
	logic [31:0]  rdata_reg;
	logic [31:0]  rdata_next;
	adcsc_state_t state_reg;
	adcsc_state_t state_next;
	logic         comp_meta_reg;
	logic         comp_sync_reg;

	// decoded strobes
	logic         wr_go;
	logic         rd_go;
	logic         wr_ctrl;
	logic         wr_clkdiv;
	logic         rd_result;
	logic         powered_off;
	logic         run;
	logic         tick;
	logic         conv_start;
	logic         conv_abort;
	logic         conv_busy;
	logic         conv_done;
	logic         irq_en;
	logic         cont_en;

	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
	assign wr_go     = avs_write_in & ~ack_reg;
	assign rd_go     = avs_read_in & ~ack_reg;
	assign wr_ctrl   = wr_go & avs_byteenable_in[0]
		& (avs_address_in == `ADCSC_OFS_CTRL);
	assign wr_clkdiv = wr_go & avs_byteenable_in[0]
		& (avs_address_in == `ADCSC_OFS_CLKDIV);
	assign rd_result = rd_go & (avs_address_in == `ADCSC_OFS_RESULT);

	assign irq_en  = ctrl_reg[`ADCSC_BIT_IRQEN];
	assign cont_en = ctrl_reg[`ADCSC_BIT_CONT];
	// all-ones channel code is power down
	assign powered_off = (ctrl_reg[`ADCSC_CH_MSB:0] == `ADCSC_CH_OFF);
	// divider halts in stop mode or power down
	assign run = ~powered_off & ~stop_mode_in;

	// bus handshake and read data
	always_comb begin
		ack_next   = rd_go | wr_go;
		rdata_next = rdata_reg;
		if (rd_go) begin
			case (avs_address_in)
				`ADCSC_OFS_CTRL:
					// flag hidden while irq mode on
					rdata_next = {24'h0, done_flag_reg & ~irq_en,
						ctrl_reg[6:0]};
				`ADCSC_OFS_RESULT: rdata_next = {24'h0, result_reg};
				`ADCSC_OFS_CLKDIV: rdata_next = {24'h0, clkdiv_reg};
				default:           rdata_next = 32'h0; // unmapped reads zero
			endcase
		end
	end

	// control registers; bit 7 of control is never written
	always_comb begin
		ctrl_next   = ctrl_reg;
		clkdiv_next = clkdiv_reg;
		if (wr_ctrl)
			ctrl_next = {1'b0, avs_writedata_in[6:0]};
		if (wr_clkdiv)
			clkdiv_next = {avs_writedata_in[`ADCSC_DIV_MSB:`ADCSC_DIV_LSB],
				5'h00};
	end

	// conversion sequencer
	always_comb begin
		state_next = state_reg;
		conv_start = 1'b0;
		conv_abort = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// a control write arms a new conversion
				if (wr_ctrl)
					state_next = ST_ARMED;
			end
			ST_ARMED: begin
				if (tick) begin
					conv_start = 1'b1;
					state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				if (conv_done) begin
					state_next = cont_en ? ST_ARMED : ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		// stop aborts, conversion restarts after exit
		if (stop_mode_in && state_reg == ST_CONV) begin
			conv_abort = 1'b1;
			state_next = ST_ARMED;
		end
		// control write restarts any running conversion
		if (wr_ctrl && state_reg != ST_IDLE) begin
			conv_abort = 1'b1;
			state_next = ST_ARMED;
		end
		if (powered_off && !wr_ctrl) begin // leaving power down still arms
			conv_abort = 1'b1;
			state_next = ST_IDLE;
		end
	end

	// result, flag and interrupt; set wins over result read clear, a control write aborts and blocks the set
	always_comb begin
		result_next    = result_reg;
		done_flag_next = done_flag_reg;
		irq_next       = irq_reg;
		if (rd_result)
			done_flag_next = 1'b0;
		// result read or control write drops request
		if (rd_result || wr_ctrl)
			irq_next = 1'b0;
		if (conv_done && state_reg == ST_CONV && !conv_abort) begin
			result_next = dac_code_out;
			if (!irq_en)
				done_flag_next = 1'b1;
			else
				irq_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_reg      <= `ADCSC_CTRL_RST;
			clkdiv_reg    <= `ADCSC_CLKDIV_RST;
			result_reg    <= 8'h00;
			done_flag_reg <= 1'b0;
			irq_reg       <= 1'b0;
			ack_reg       <= 1'b0;
			rdata_reg     <= 32'h0;
			state_reg     <= ST_IDLE;
		end else begin
			ctrl_reg      <= ctrl_next;
			clkdiv_reg    <= clkdiv_next;
			result_reg    <= result_next;
			done_flag_reg <= done_flag_next;
			irq_reg       <= irq_next;
			ack_reg       <= ack_next;
			rdata_reg     <= rdata_next;
			state_reg     <= state_next;
		end
	end

	// comparator comes from analog, so two stages before use
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			comp_meta_reg <= 1'b0;
			comp_sync_reg <= 1'b0;
		end else begin
			comp_meta_reg <= comp_in;
			comp_sync_reg <= comp_meta_reg;
		end
	end

	adcsc_clkdiv u_clkdiv (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.run_in     (run),
		.div_sel_in (clkdiv_reg[`ADCSC_DIV_MSB:`ADCSC_DIV_LSB]),
		.tick_out   (tick)
	);

	adcsc_sar u_sar (
		.ref_clk_in   (ref_clk_in),
		.rstn_in      (rstn_in),
		.start_in     (conv_start),
		.abort_in     (conv_abort),
		.tick_in      (tick),
		.comp_in      (comp_sync_reg),
		.dac_code_out (dac_code_out),
		.busy_out     (conv_busy),
		.done_out     (conv_done)
	);

	// analog side controls
	// low codes pass to the input mux
	assign mux_sel_out      = ctrl_reg[`ADCSC_CH_MSB:0];
	assign ref_high_sel_out = (ctrl_reg[`ADCSC_CH_MSB:0] == `ADCSC_CH_REFHI);
	assign ref_low_sel_out  = (ctrl_reg[`ADCSC_CH_MSB:0] == `ADCSC_CH_REFLO);
	assign power_down_out   = powered_off;
	assign sampling_out     = (state_reg == ST_ARMED);
	assign irq_out          = irq_reg;
	assign avs_readdata_out = rdata_reg;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_done_polled;
		conv_done && state_reg == ST_CONV && !conv_abort && !irq_en;
	endsequence

	sequence s_done_irq;
		conv_done && state_reg == ST_CONV && !conv_abort && irq_en;
	endsequence

	property p_flag_set;
		s_done_polled |=> done_flag_reg;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("done flag not set after polled conversion");

	property p_flag_hold;
		done_flag_reg && !rd_result |=> done_flag_reg;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("done flag dropped without result read");

	property p_flag_irq_mode;
		irq_en && !done_flag_reg |=> !done_flag_reg || !irq_en;
	endproperty
	a_flag_irq_mode: assert property (p_flag_irq_mode)
		else $error("done flag set in interrupt mode");

	property p_irq_raise;
		s_done_irq ##1 !(rd_result || wr_ctrl) |-> irq_out;
	endproperty
	a_irq_raise: assert property (p_irq_raise)
		else $error("no interrupt after conversion end");

	property p_irq_clear;
		irq_out && (rd_result || wr_ctrl) && !conv_done |=> !irq_out;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt not removed by clearing access");

	property p_irq_level;
		irq_out && !rd_result && !wr_ctrl |=> irq_out;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt request fell without clear");

	property p_result_update;
		s_done_polled or s_done_irq |=> result_reg == $past(dac_code_out);
	endproperty
	a_result_update: assert property (p_result_update)
		else $error("result not loaded at conversion end");

	property p_single_stop;
		conv_done && state_reg == ST_CONV && !cont_en && !wr_ctrl
			|=> state_reg == ST_IDLE [*2];
	endproperty
	a_single_stop: assert property (p_single_stop)
		else $error("single mode did not stop");

	property p_cont_rearm;
		conv_done && state_reg == ST_CONV && cont_en && run
			|=> state_reg == ST_ARMED;
	endproperty
	a_cont_rearm: assert property (p_cont_rearm)
		else $error("continuous mode did not rearm");

	property p_powerdown_quiet;
		powered_off && !wr_ctrl |=> state_reg == ST_IDLE && !conv_busy;
	endproperty
	a_powerdown_quiet: assert property (p_powerdown_quiet)
		else $error("conversion active while powered down");

	property p_stop_abort;
		stop_mode_in && state_reg == ST_CONV |=> !conv_busy;
	endproperty
	a_stop_abort: assert property (p_stop_abort)
		else $error("conversion not aborted in stop mode");

	property p_bus_answer;
		(avs_read_in || avs_write_in) && avs_waitrequest_out
			|=> !avs_waitrequest_out;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer not given on next cycle");
endmodule : adcsc_top

// File: verification/adcsc_analog_model.sv
module adcsc_analog_model (
	input  wire logic                   ref_clk_in,
	input  wire adcsc_pkg::adcsc_chan_t mux_sel_in,
	input  wire logic                   ref_high_sel_in,
	input  wire logic                   ref_low_sel_in,
	input  wire logic                   power_down_in,
	input  wire adcsc_pkg::adcsc_byte_t dac_code_in,
	input  wire logic [31:0]            levels_in,
	output logic                        comp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import adcsc_pkg::*;
	adcsc_byte_t lvl;
	logic        valid;
	logic        junk_reg = 1'b0;
	always_comb begin
		valid = 1'b1;
		lvl = 8'h00;
		if (ref_high_sel_in) begin
			lvl = 8'hff;
		end else if (ref_low_sel_in) begin
			lvl = 8'h00;
		end else if (mux_sel_in < 5'h04) begin
			lvl = levels_in[mux_sel_in[1:0] * 8 +: 8];
		end else begin
			valid = 1'b0;
		end
	end
	// meaningless output toggles so a stale value never looks right
	always @(posedge ref_clk_in) begin
		junk_reg <= ~junk_reg;
	end
	assign comp_out = (valid && !power_down_in) ? (lvl >= dac_code_in)
		: junk_reg;
endmodule : adcsc_analog_model

// File: verification/adcsc_top_bench.sv
`include "adcsc_defines.svh"
module adcsc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import adcsc_pkg::*;
	logic        clk;
	logic        rstn;
	logic [3:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        waitreq;
	logic        stop_mode;
	logic        comp;
	adcsc_chan_t mux_sel;
	logic        ref_hi;
	logic        ref_lo;
	logic        pwr_dn;
	adcsc_byte_t dac_code;
	logic        sampling;
	logic        irq;
	logic [31:0] levels;
	logic [31:0] rv;
	int          n_errors;
	int          tests_run;

	adcsc_top adcsc_top_inst (
		.ref_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq), .stop_mode_in(stop_mode),
		.comp_in(comp), .mux_sel_out(mux_sel), .ref_high_sel_out(ref_hi),
		.ref_low_sel_out(ref_lo), .power_down_out(pwr_dn),
		.dac_code_out(dac_code), .sampling_out(sampling), .irq_out(irq)
	);
	adcsc_analog_model adcsc_analog_model_inst (
		.ref_clk_in(clk), .mux_sel_in(mux_sel), .ref_high_sel_in(ref_hi),
		.ref_low_sel_in(ref_lo), .power_down_in(pwr_dn),
		.dac_code_in(dac_code), .levels_in(levels), .comp_out(comp)
	);

	// 250 MHz bus clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic hang(input string what);
		n_errors++;
		$display("mismatch %0t wait ran out: %s", $time, what);
		finish_test();
	endtask : hang

	// one avalon cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d, input logic [3:0] b);
		int k;
		k = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		be <= b;
		do begin
			@(posedge clk);
			k++;
			if (k > 20) hang("bus");
		end while (waitreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	// control writes keep bit 7 clear
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, (a == `ADCSC_OFS_CTRL) ? {1'b0, d[6:0]} : d, 4'h1);
	endtask : wr8

	task automatic rd8(input logic [3:0] a);
		bus(1'b0, a, 8'h00, 4'hf);
	endtask : rd8

	task automatic poll_flag();
		int k;
		k = 0;
		do begin
			rd8(`ADCSC_OFS_CTRL);
			k++;
			if (k > 300) hang("flag");
		end while (rv[7] !== 1'b1);
	endtask : poll_flag

	task automatic t_reset();
		rd8(`ADCSC_OFS_CTRL);
		check(rv, 32'h1f, "ctrl rst");
		check(32'(mux_sel), 32'h1f, "mux rst");
		check(32'(pwr_dn), 32'h1, "pdn rst");
		rd8(`ADCSC_OFS_RESULT);
		check(rv, 32'h0, "result rst");
		rd8(`ADCSC_OFS_CLKDIV);
		check(rv, 32'h0, "div rst");
		rd8(4'hc);
		check(rv, 32'h0, "unmapped");
		wr8(`ADCSC_OFS_CLKDIV, 8'hff);
		bus(1'b1, `ADCSC_OFS_CLKDIV, 8'h00, 4'h0);
		rd8(`ADCSC_OFS_CLKDIV);
		check(rv, 32'he0, "div field");
		$display("test reset and registers done");
	endtask : t_reset

	task automatic t_single();
		logic [7:0] codes[6];
		logic [7:0] exps[6];
		codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h1d, 8'h1e};
		exps = '{8'h27, 8'h81, 8'h5a, 8'hc3, 8'hff, 8'h00};
		wr8(`ADCSC_OFS_CLKDIV, 8'h40);
		wr8(`ADCSC_OFS_CTRL, 8'h00);
		poll_flag();
		rd8(`ADCSC_OFS_RESULT);
		foreach (codes[i]) begin
			wr8(`ADCSC_OFS_CTRL, codes[i]);
			check(32'(mux_sel), 32'(codes[i][4:0]), "mux");
			check(32'(ref_hi), 32'(codes[i] == 8'h1d), "ref hi");
			check(32'(ref_lo), 32'(codes[i] == 8'h1e), "ref lo");
			poll_flag();
			repeat (100) @(posedge clk);
			rd8(`ADCSC_OFS_CTRL);
			check(32'(rv[7]), 32'h1, "flag held");
			rd8(`ADCSC_OFS_RESULT);
			check(rv, 32'(exps[i]), "result");
			rd8(`ADCSC_OFS_CTRL);
			check(rv, 32'(codes[i]), "flag cleared");
		end
		repeat (200) @(posedge clk);
		rd8(`ADCSC_OFS_CTRL);
		check(rv, 32'h1e, "single stopped");
		check(32'(sampling), 32'h0, "single idle");
		$display("test single conversions done");
	endtask : t_single

	task automatic t_irq();
		int n;
		int dv;
		for (int s = 0; s < 8; s++) begin
			wr8(`ADCSC_OFS_CLKDIV, {s[2:0], 5'h00});
			wr8(`ADCSC_OFS_CTRL, 8'h40);
			check(32'(irq), 32'h0, "irq write clr");
			n = 0;
			while (irq !== 1'b1) begin
				@(posedge clk);
				n++;
				if (n > 400) hang("irq");
			end
			dv = s[2] ? 16 : (1 << s);
			check(32'(n >= 16 * dv && n <= 17 * dv + 8), 1, "time");
			repeat (20) @(posedge clk);
			check(32'(irq), 32'h1, "irq level");
			rd8(`ADCSC_OFS_CTRL);
			check(32'(rv[7]), 32'h0, "flag irq");
		end
		rd8(`ADCSC_OFS_RESULT);
		check(32'(irq), 32'h0, "irq read clr");
		$display("test interrupt and timing done");
	endtask : t_irq

	task automatic t_cont();
		wr8(`ADCSC_OFS_CLKDIV, 8'h40);
		wr8(`ADCSC_OFS_CTRL, 8'h22);
		poll_flag();
		rd8(`ADCSC_OFS_RESULT);
		check(rv, 32'h5a, "cont first");
		levels[23:16] <= 8'h3c;
		repeat (250) @(posedge clk);
		rd8(`ADCSC_OFS_RESULT);
		check(rv, 32'h3c, "overwrite");
		poll_flag();
		$display("test continuous done");
	endtask : t_cont

	task automatic t_stop();
		stop_mode <= 1'b1;
		repeat (2) @(posedge clk);
		rd8(`ADCSC_OFS_RESULT);
		repeat (200) @(posedge clk);
		check(32'(sampling), 32'h1, "stop armed");
		rd8(`ADCSC_OFS_CTRL);
		check(32'(rv[7]), 32'h0, "stop flag");
		stop_mode <= 1'b0;
		poll_flag();
		rd8(`ADCSC_OFS_RESULT);
		check(rv, 32'h3c, "resume");
		wr8(`ADCSC_OFS_CTRL, 8'h1f);
		check(32'(pwr_dn), 32'h1, "pdn");
		rd8(`ADCSC_OFS_RESULT); // discard cut conversion
		repeat (300) @(posedge clk);
		rd8(`ADCSC_OFS_CTRL);
		check(rv, 32'h1f, "pdn no conv");
		$display("test stop and power down done");
	endtask : t_stop

	// main sequence, reset held for three clocks
	initial begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		be = 4'h0;
		stop_mode = 1'b0;
		levels = 32'hc3_5a_81_27;
		n_errors = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_single();
		t_irq();
		t_cont();
		t_stop();
		finish_test();
	end
endmodule : adcsc_top_bench
